// *** logic/pd_ctrl.sv ***
// Purpose: stop/idle power-down control and reset values of peripheral registers
// Assumes: cpu core on sys_clk presents opcodes and interrupt returns as pulses
// Notes: sys_clk is modelled as running; main_osc_en tells the clock tree what to stop
//
// Functional notes
// (R1) stop opcode halts cpu, peripherals, main oscillator
// (R2) stop ends only by reset or wake interrupt
// (R3) reset from stop restores defaults, divider 1/16
// (R4) after reset wait stabilisation, fetch 0100H
// (R5) four external wake inputs end stop
// (R6) interrupt wake keeps controls except stop control
// (R7) interrupt wake keeps clock select bits
// (R8) service waking interrupt, then resume after stop
// (R9) watch timer on sub oscillator ends stop
// (R10) stop control written before stop opcode
// (R11) software sets stabilisation before stop
// (R12) idle gates cpu clock only
// (R13) reset from idle restores defaults, divider 1/16
// (R14) masked interrupts cannot end idle
// (R15) enabled interrupt ends idle, clock kept
// (R16) data registers reset to all ones
// (R17) listed control registers reset to zero
// (R18) port3 high config resets from option
// (R19) only implemented pending bits clear
// (R20) serial data undefined, converter high two bits
// (R21) unused bits read as zero
// (R22) reset disables interrupts, enables watchdog
// (R23) wake synchronised, cpu gated until stable
// (R24) reset clears latch, running wakes ignored
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module pd_ctrl
   import pd_ctrl_pkg::*;
#(
   parameter logic [STAB_CNT_W-1:0] RESET_STAB_LEN = STAB_CNT_W'(RESET_STAB_CYCLES)
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // cpu core
   input wire logic [7:0] opcode,
   input wire logic opcode_valid,
   input wire logic irq_pending,
   input wire logic int_return,
   // wake pins and option straps
   input wire logic [3:0] external_wake_inputs,
   input wire logic watch_irq,
   input wire logic watch_on_sub,
   input wire logic [7:0] port3_high_option,
   // clock and sequencing controls
   output logic cpu_clk_en,
   output logic main_osc_en,
   output logic periph_clk_en,
   output logic [1:0] clk_div_sel,
   output logic fetch_start,
   output logic [15:0] fetch_addr,
   output logic irq_service,
   output logic resume_next,
   output logic int_enable,
   output logic watchdog_en
);
   pd_state_t state_reg;
   pd_state_t state_next;
   logic [7:0] gen_reg [NUM_GEN];
   logic [7:0] system_clock_divider_control;
   logic [7:0] stop_control_register;
   logic [7:0] port3_high_config;
   logic [7:0] port3_pending_flags;
   logic [7:0] serial_data_register;
   logic [7:0] pd_ctrl_reg;
   logic [1:0] strap_cnt_reg;
   logic [SYNC_W-1:0] sync_lvl;
   logic [3:0] ext_sync;
   logic [3:0] ext_prev_reg;
   logic [7:0] port3_high_sync;
   logic watch_wake;
   logic stop_wake;
   logic stop_cmd;
   logic idle_cmd;
   logic stab_load;
   logic stab_done;
   logic [STAB_CNT_W-1:0] stab_len;
   logic [7:0] rd_val;
   logic [7:0] reg_rdata_reg;
   logic cpu_clk_en_reg;
   logic main_osc_en_reg;
   logic periph_clk_en_reg;
   logic fetch_start_reg;
   logic [15:0] fetch_addr_reg;
   logic irq_service_reg;
   logic resume_next_reg;

   // every pin, strap included, crosses two flops before use
   level_sync #(.W(SYNC_W)) u_sync (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .async_in({port3_high_option, watch_on_sub, watch_irq, external_wake_inputs}),
      .sync_out(sync_lvl)
   );

   assign ext_sync = sync_lvl[3:0];
   assign port3_high_sync = sync_lvl[13:6];
   assign watch_wake = sync_lvl[4] & sync_lvl[5] & gen_reg[IDX_WATCH_CTRL][WT_SUB_WAKE_BIT]; // [R9]
   assign stop_wake = (|(ext_sync & gen_reg[IDX_P3_INT][3:0])) | watch_wake; // [R5] [R23]
   assign stop_cmd = opcode_valid && (opcode == OP_STOP) && (stop_control_register == STOP_ARM_CODE); // [R10]
   assign idle_cmd = opcode_valid && (opcode == OP_IDLE);
   // the interval for an interrupt wake is whatever software left before stop
   assign stab_len = STAB_STEP_CYCLES << (2 * pd_ctrl_reg[PD_STAB_LSB +: 2]); // [R11]
   assign stab_load = (state_reg == ST_STOP) && stop_wake;

   // reset-time stabilisation runs straight out of reset
   stab_timer #(.RESET_CYCLES(RESET_STAB_LEN)) u_stab (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .load(stab_load),
      .load_val(stab_len),
      .done(stab_done)
   );

   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         ST_RST_WAIT: if (stab_done) state_next = ST_RUN; // [R4]
         ST_RUN:
         begin
            // a refused stop (not armed) behaves as a no-op
            if (stop_cmd) state_next = ST_STOP; // [R1]
            else if (idle_cmd) state_next = ST_IDLE; // [R12]
         end
         ST_STOP: if (stop_wake) state_next = ST_WAKE_WAIT; // [R2]
         ST_IDLE: if (irq_pending && pd_ctrl_reg[PD_INT_EN_BIT]) state_next = ST_SERVICE; // [R14] [R15]
         ST_WAKE_WAIT: if (stab_done) state_next = ST_SERVICE; // [R23]
         ST_SERVICE: if (int_return) state_next = ST_RUN; // [R8]
      endcase
   end

   // async reset is the only way out of stop or idle besides a wake
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         state_reg <= ST_RST_WAIT; // [R24] [R2]
      else
         state_reg <= state_next;
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cpu_clk_en_reg <= 1'b0;
         main_osc_en_reg <= 1'b1;
         periph_clk_en_reg <= 1'b1;
      end
      else
      begin
         cpu_clk_en_reg <= (state_next == ST_RUN) || (state_next == ST_SERVICE); // [R12] [R23]
         main_osc_en_reg <= (state_next != ST_STOP); // [R1]
         periph_clk_en_reg <= (state_next != ST_STOP); // [R1] [R12]
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fetch_start_reg <= 1'b0;
         fetch_addr_reg <= RESET_VECTOR; // [R4]
         irq_service_reg <= 1'b0;
         resume_next_reg <= 1'b0;
      end
      else
      begin
         fetch_start_reg <= (state_reg == ST_RST_WAIT) && stab_done; // [R4]
         fetch_addr_reg <= RESET_VECTOR;
         irq_service_reg <= (state_reg != ST_SERVICE) && (state_next == ST_SERVICE); // [R8] [R15]
         resume_next_reg <= (state_reg == ST_SERVICE) && int_return; // [R8]
      end
   end

   // plain registers
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < NUM_GEN; i++)
            gen_reg[i] <= GEN_RST[i]; // [R16] [R17] [R19] [R20]
      end
      else
      begin
         for (int i = 0; i < NUM_GEN; i++)
            if (reg_wr && (reg_addr == GEN_ADDR[i]))
               gen_reg[i] <= reg_wdata & GEN_MASK[i]; // [R21]
      end
   end

   // clock select survives wakes; only reset clears it to divide-by-16
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         system_clock_divider_control <= CLK_DIV_RST; // [R3] [R13]
      else if (reg_wr && (reg_addr == ADDR_CLK_DIV))
         system_clock_divider_control <= reg_wdata & CLK_DIV_MASK; // [R7]
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         stop_control_register <= STOP_CTRL_RST;
      else if (stab_load)
         stop_control_register <= STOP_CTRL_RST; // [R6]
      else if (reg_wr && (reg_addr == ADDR_STOP_CTRL))
         stop_control_register <= reg_wdata;
   end

   // strap is sampled after release; writes in that short window are overridden
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         strap_cnt_reg <= 2'h0;
         port3_high_config <= 8'h00;
      end
      else if (strap_cnt_reg != STRAP_LOAD_CYCLES)
      begin
         strap_cnt_reg <= strap_cnt_reg + 2'h1;
         port3_high_config <= port3_high_sync; // [R18]
      end
      else if (reg_wr && (reg_addr == ADDR_P3_HIGH))
         port3_high_config <= reg_wdata;
   end

   // pending: rising synced pin sets, write one clears, set wins
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ext_prev_reg <= 4'h0;
         port3_pending_flags <= 8'h00; // [R19]
      end
      else
      begin
         ext_prev_reg <= ext_sync;
         if (reg_wr && (reg_addr == ADDR_P3_PEND))
            port3_pending_flags <= ((port3_pending_flags & ~reg_wdata) | {4'h0, ext_sync & ~ext_prev_reg})
               & P3_PEND_MASK;
         else
            port3_pending_flags <= (port3_pending_flags | {4'h0, ext_sync & ~ext_prev_reg}) & P3_PEND_MASK;
      end
   end

   // no reset: contents are undefined after reset by design
   always_ff @(posedge sys_clk)
   begin
      if (reg_wr && (reg_addr == ADDR_SERIAL_DATA))
         serial_data_register <= reg_wdata; // [R20]
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         pd_ctrl_reg <= PD_CTRL_RST; // [R22]
      else if (reg_wr && (reg_addr == ADDR_PD_CTRL))
         pd_ctrl_reg <= reg_wdata & PD_CTRL_MASK;
   end

   always_comb
   begin
      rd_val = 8'h00; // [R21]
      for (int i = 0; i < NUM_GEN; i++)
         if (reg_addr == GEN_ADDR[i])
            rd_val = gen_reg[i];
      unique case (reg_addr)
         ADDR_CLK_DIV: rd_val = system_clock_divider_control;
         ADDR_STOP_CTRL: rd_val = stop_control_register;
         ADDR_P3_HIGH: rd_val = port3_high_config;
         ADDR_P3_PEND: rd_val = port3_pending_flags;
         ADDR_SERIAL_DATA: rd_val = serial_data_register;
         ADDR_PD_CTRL: rd_val = pd_ctrl_reg;
         ADDR_PD_STATUS: rd_val = {5'h00, state_reg};
         default: ;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         reg_rdata_reg <= 8'h00;
      else
         reg_rdata_reg <= reg_rd ? rd_val : 8'h00;
   end

   assign reg_rdata = reg_rdata_reg;
   assign cpu_clk_en = cpu_clk_en_reg;
   assign main_osc_en = main_osc_en_reg;
   assign periph_clk_en = periph_clk_en_reg;
   assign clk_div_sel = system_clock_divider_control[CLK_SEL_LSB +: 2];
   assign fetch_start = fetch_start_reg;
   assign fetch_addr = fetch_addr_reg;
   assign irq_service = irq_service_reg;
   assign resume_next = resume_next_reg;
   assign int_enable = pd_ctrl_reg[PD_INT_EN_BIT];
   assign watchdog_en = pd_ctrl_reg[PD_WDOG_BIT];

   property p_stop_entry;
      @(posedge sys_clk) disable iff (!rst_n)
      (state_reg == ST_RUN) && stop_cmd |=> (state_reg == ST_STOP) && !main_osc_en && !cpu_clk_en && !periph_clk_en;
   endproperty
   a_stop_entry: assert property (p_stop_entry) else $error("stop entry did not halt clocks"); // [R1]

   property p_stop_unarmed;
      @(posedge sys_clk) disable iff (!rst_n)
      (state_reg == ST_RUN) && opcode_valid && (opcode == OP_STOP) && (stop_control_register != STOP_ARM_CODE)
         |=> (state_reg == ST_RUN) && cpu_clk_en;
   endproperty
   a_stop_unarmed: assert property (p_stop_unarmed) else $error("unarmed stop was taken"); // [R10]

   property p_stop_hold;
      @(posedge sys_clk) disable iff (!rst_n)
      (state_reg == ST_STOP) && !stop_wake |=> (state_reg == ST_STOP);
   endproperty
   a_stop_hold: assert property (p_stop_hold) else $error("stop left without wake"); // [R2]

   property p_stop_wake;
      @(posedge sys_clk) disable iff (!rst_n)
      (state_reg == ST_STOP) && stop_wake |=> (state_reg == ST_WAKE_WAIT) && main_osc_en && !cpu_clk_en
         && (stop_control_register == STOP_CTRL_RST) && $stable(clk_div_sel);
   endproperty
   a_stop_wake: assert property (p_stop_wake) else $error("wake from stop mishandled"); // [R5] [R6] [R7]

   property p_wake_gated;
      @(posedge sys_clk) disable iff (!rst_n)
      (state_reg == ST_WAKE_WAIT) && !stab_done |=> !cpu_clk_en && !irq_service;
   endproperty
   a_wake_gated: assert property (p_wake_gated) else $error("cpu clock before stabilisation"); // [R23]

   property p_wake_service;
      @(posedge sys_clk) disable iff (!rst_n)
      (state_reg == ST_WAKE_WAIT) && stab_done |=> irq_service && cpu_clk_en ##1 !irq_service;
   endproperty
   a_wake_service: assert property (p_wake_service) else $error("waking interrupt not serviced"); // [R8]

   property p_idle_state;
      @(posedge sys_clk) disable iff (!rst_n)
      (state_reg == ST_IDLE) |-> !cpu_clk_en && periph_clk_en && main_osc_en;
   endproperty
   a_idle_state: assert property (p_idle_state) else $error("idle gating wrong"); // [R12]

   property p_idle_masked;
      @(posedge sys_clk) disable iff (!rst_n)
      (state_reg == ST_IDLE) && !int_enable |=> (state_reg == ST_IDLE);
   endproperty
   a_idle_masked: assert property (p_idle_masked) else $error("masked interrupt left idle"); // [R14]

   property p_idle_wake;
      @(posedge sys_clk) disable iff (!rst_n)
      (state_reg == ST_IDLE) && irq_pending && int_enable |=> irq_service && cpu_clk_en && $stable(clk_div_sel);
   endproperty
   a_idle_wake: assert property (p_idle_wake) else $error("enabled interrupt did not end idle"); // [R15]

   property p_resume;
      @(posedge sys_clk) disable iff (!rst_n)
      (state_reg == ST_SERVICE) && int_return |=> resume_next && (state_reg == ST_RUN) ##1 !resume_next;
   endproperty
   a_resume: assert property (p_resume) else $error("no resume after interrupt return"); // [R8]

   property p_reset_fetch;
      @(posedge sys_clk) disable iff (!rst_n)
      (state_reg == ST_RST_WAIT) && stab_done |=> fetch_start && (fetch_addr == 16'h0100) && cpu_clk_en;
   endproperty
   a_reset_fetch: assert property (p_reset_fetch) else $error("reset fetch wrong"); // [R4]
endmodule // pd_ctrl

// *** logic/pd_ctrl_pkg.sv ***
// Purpose: shared constants and types of the power-down and reset-value controller
// Assumes: 8-bit register bus, 200 MHz sys_clk
// Notes: pd_ctrl and pd_status are local additions beside the printed map
package pd_ctrl_pkg;
   // opcodes decoded from the cpu core
   localparam logic [7:0] OP_STOP = 8'h7F;
   localparam logic [7:0] OP_IDLE = 8'h6F;
   localparam logic [15:0] RESET_VECTOR = 16'h0100;
   // timing
   localparam int SYS_CLK_PERIOD_NS = 5;
   localparam int RESET_STAB_NS = 1000000;
   localparam int RESET_STAB_CYCLES = (RESET_STAB_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
   localparam int STAB_CNT_W = 18;
   localparam logic [STAB_CNT_W-1:0] STAB_STEP_CYCLES = 18'h00100;
   localparam logic [1:0] STRAP_LOAD_CYCLES = 2'h3;
   localparam int SYNC_W = 14;
   // special register offsets
   localparam logic [7:0] ADDR_CLK_DIV = 8'hD4;
   localparam logic [7:0] ADDR_STOP_CTRL = 8'hD7;
   localparam logic [7:0] ADDR_P3_HIGH = 8'hEC;
   localparam logic [7:0] ADDR_P3_PEND = 8'hEF;
   localparam logic [7:0] ADDR_SERIAL_DATA = 8'hFF;
   localparam logic [7:0] ADDR_PD_CTRL = 8'h30;
   localparam logic [7:0] ADDR_PD_STATUS = 8'h31;
   // fields and reset values
   localparam logic [7:0] CLK_DIV_MASK = 8'h98;
   localparam logic [7:0] CLK_DIV_RST = 8'h00;
   localparam int CLK_SEL_LSB = 3;
   localparam logic [7:0] STOP_CTRL_RST = 8'h00;
   localparam logic [7:0] STOP_ARM_CODE = 8'hA5;
   localparam logic [7:0] P3_PEND_MASK = 8'h0F;
   localparam logic [7:0] PD_CTRL_MASK = 8'h0F;
   localparam logic [7:0] PD_CTRL_RST = 8'h02;
   localparam int PD_INT_EN_BIT = 0;
   localparam int PD_WDOG_BIT = 1;
   localparam int PD_STAB_LSB = 2;
   localparam int WT_SUB_WAKE_BIT = 0;
   // plain registers: offset, reset value, implemented bits
   localparam int NUM_GEN = 21;
   localparam logic [7:0] GEN_ADDR [NUM_GEN] = '{8'hEA, 8'hEB, 8'hED, 8'hEE, 8'hF0, 8'hF1, 8'hF2,
      8'hF3, 8'hF4, 8'hF5, 8'hF6, 8'hF7, 8'hF8, 8'hF9, 8'hFA, 8'hFB, 8'hFC, 8'hFD, 8'hFE, 8'h14, 8'h15};
   localparam logic [7:0] GEN_RST [NUM_GEN] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF};
   localparam logic [7:0] GEN_MASK [NUM_GEN] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'hFF, 8'h07,
      8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h03, 8'hFF, 8'hFF, 8'hFF, 8'h33, 8'hFF, 8'hFF};
   localparam int IDX_P3_INT = 3;
   localparam int IDX_WATCH_CTRL = 13;
   typedef enum logic [2:0] {ST_RST_WAIT, ST_RUN, ST_STOP, ST_IDLE, ST_WAKE_WAIT, ST_SERVICE} pd_state_t;
endpackage

// *** logic/level_sync.sv ***
// Purpose: two-flop synchroniser for pin levels
// Assumes: inputs are slow levels, not single-cycle pulses
// Notes: only the second stage leaves this module
`timescale 1ns/1ps
module level_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // levels
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] sync_reg;

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_reg <= '0;
         sync_reg <= '0;
      end
      else
      begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
      end
   end

   assign sync_out = sync_reg;
endmodule // level_sync

// *** logic/stab_timer.sv ***
// Purpose: oscillation stabilisation down-counter
// Assumes: load value is never zero
// Notes: starts counting out of reset; done holds until the next load
`timescale 1ns/1ps
module stab_timer
   import pd_ctrl_pkg::*;
#(
   parameter logic [STAB_CNT_W-1:0] RESET_CYCLES = STAB_CNT_W'(RESET_STAB_CYCLES)
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // control
   input wire logic load,
   input wire logic [STAB_CNT_W-1:0] load_val,
   output logic done
);
   logic [STAB_CNT_W-1:0] count_reg;
   logic done_reg;

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count_reg <= RESET_CYCLES;
         done_reg <= 1'b0;
      end
      else if (load)
      begin
         count_reg <= load_val;
         done_reg <= 1'b0;
      end
      else if (count_reg != '0)
      begin
         count_reg <= count_reg - 1'b1;
         done_reg <= (count_reg == STAB_CNT_W'(1));
      end
   end

   assign done = done_reg;
endmodule // stab_timer

// *** verification/cpu_core_model.sv ***
// Purpose: cpu core stand-in that issues opcodes and interrupt returns
// Assumes: the bench requests opcodes one at a time
// Notes: service routine length is set per wake by ret_wait
`timescale 1ns/1ps
module cpu_core_model (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // bench requests
   input wire logic op_req,
   input wire logic [7:0] op_code,
   input wire logic [7:0] ret_wait,
   // controller side
   input wire logic irq_service,
   output logic [7:0] opcode,
   output logic opcode_valid,
   output logic int_return
);
   logic [8:0] ret_cnt_reg;
   // unqualified opcode bus keeps moving so a stale stop code never looks valid
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         opcode <= 8'h00;
         opcode_valid <= 1'b0;
      end
      else
      begin
         opcode_valid <= op_req;
         opcode <= op_req ? op_code : opcode + 8'h35;
      end
   end
   // service routine lasts ret_wait + 2 cycles after irq_service rises, then one return is executed
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ret_cnt_reg <= 9'h000;
         int_return <= 1'b0;
      end
      else
      begin
         int_return <= (ret_cnt_reg == 9'h001);
         if (irq_service)
            ret_cnt_reg <= {1'b0, ret_wait} + 9'h001;
         else if (ret_cnt_reg != 9'h000)
            ret_cnt_reg <= ret_cnt_reg - 9'h001;
      end
   end
endmodule // cpu_core_model

// *** verification/tb_pd_ctrl.sv ***
// Purpose: self-checking bench for pd_ctrl
// Assumes: cpu_core_model answers service requests
// Notes: reset wait shortened to 20 cycles
`timescale 1ns/1ps
module tb_pd_ctrl;
   localparam int N = 20;
   localparam logic [15:0] RT [23] = '{16'hF5FF, 16'hF6FF, 16'hF7FF, 16'h14FF, 16'h15FF, 16'hF300, 16'hF400,
      16'hF800, 16'hF900, 16'hFC00, 16'hFD00, 16'hEA00, 16'hEB00, 16'hED00, 16'hEF00, 16'hF200, 16'hFE00,
      16'hFA00, 16'hD700, 16'hD400, 16'h3002, 16'hEC5A, 16'h5000};
   localparam logic [15:0] WM [6] = '{16'hF03F, 16'hF207, 16'hFA03, 16'hFE33, 16'hD498, 16'h5000};
   logic sys_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, op_req = 1'b0;
   logic irq_pending = 1'b0, watch_irq = 1'b0, watch_on_sub = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, op_code = 8'h00, ret_wait = 8'h00, reg_rdata, opcode;
   logic [3:0] ext_in = 4'h0;
   logic opcode_valid, int_return, cpu_clk_en, main_osc_en, periph_clk_en;
   logic fetch_start, irq_service, resume_next, int_enable, watchdog_en;
   logic [1:0] clk_div_sel;
   logic [15:0] fetch_addr;
   int miscompares = 0, num_checks = 0, cyc = 0, n, hi, lv;
   initial
   begin
      forever #2.5 sys_clk = ~sys_clk;
   end
   pd_ctrl #(.RESET_STAB_LEN(18'(N))) dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .opcode(opcode),
      .opcode_valid(opcode_valid), .irq_pending(irq_pending), .int_return(int_return),
      .external_wake_inputs(ext_in), .watch_irq(watch_irq), .watch_on_sub(watch_on_sub),
      .port3_high_option(8'h5A), .cpu_clk_en(cpu_clk_en), .main_osc_en(main_osc_en),
      .periph_clk_en(periph_clk_en), .clk_div_sel(clk_div_sel), .fetch_start(fetch_start),
      .fetch_addr(fetch_addr), .irq_service(irq_service), .resume_next(resume_next),
      .int_enable(int_enable), .watchdog_en(watchdog_en));
   cpu_core_model core (.sys_clk(sys_clk), .rst_n(rst_n), .op_req(op_req), .op_code(op_code),
      .ret_wait(ret_wait), .irq_service(irq_service), .opcode(opcode), .opcode_valid(opcode_valid),
      .int_return(int_return));
   task end_sim;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task chk(input string s, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", s, exp, seen);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      chk($sformatf("reg %h", a), {8'h00, reg_rdata}, {8'h00, e});
   endtask
   task op(input logic [7:0] c);
      @(posedge sys_clk);
      op_code <= c;
      op_req <= 1'b1;
      @(posedge sys_clk);
      op_req <= 1'b0;
      @(posedge sys_clk);
      #1;
   endtask
   function automatic logic pick(input int k);
      return k == 0 ? irq_service : (k == 1 ? resume_next : fetch_start);
   endfunction
   // hi counts cycles with the cpu clock on before the awaited pulse
   task await_pulse(input int k, input int lim);
      n = 0;
      hi = 0;
      while (pick(k) !== 1'b1 && n < lim)
      begin
         @(posedge sys_clk);
         #1;
         n++;
         if (cpu_clk_en === 1'b1 && pick(k) !== 1'b1)
            hi++;
      end
      chk($sformatf("pulse %0d", k), pick(k), 1'b1);
   endtask
   task do_reset;
      @(posedge sys_clk);
      rst_n <= 1'b0;
      repeat (8) @(posedge sys_clk);
      chk("clk_en", {cpu_clk_en, main_osc_en, periph_clk_en}, 3'b011);
      chk("int_wdog", {int_enable, watchdog_en}, 2'b01);
      chk("div_sel", clk_div_sel, 2'b00);
      rst_n <= 1'b1;
      await_pulse(2, N + 10);
      chk("fetch_wait", n >= N && n <= N + 4, 1'b1);
      chk("early_clk", hi, 0);
      chk("fetch_addr", fetch_addr, 16'h0100);
   endtask
   initial
   begin
      do_reset;
      foreach (RT[i]) rd(RT[i][15:8], RT[i][7:0]);
      foreach (WM[i])
      begin
         wr(WM[i][15:8], 8'hFF);
         rd(WM[i][15:8], WM[i][7:0]);
      end
      wr(8'hD4, 8'h08);
      op(8'h7F);
      rd(8'h31, 8'h01);
      for (int i = 0; i < 4; i++)
      begin
         lv = 256 << (2 * (i % 2));
         wr(8'h30, {4'h0, 2'(i % 2), 2'b10});
         wr(8'hEE, 8'h01 << i);
         wr(8'hD7, 8'hA5);
         op(8'h7F);
         chk("stop_en", {main_osc_en, periph_clk_en, cpu_clk_en}, 3'b000);
         @(posedge sys_clk);
         ext_in <= 4'h1 << ((i + 1) % 4);
         irq_pending <= 1'b1;
         repeat (8) @(posedge sys_clk);
         #1;
         chk("stop_held", main_osc_en, 1'b0);
         @(posedge sys_clk);
         ext_in <= 4'h1 << i;
         irq_pending <= 1'b0;
         ret_wait <= 8'(i * 30);
         await_pulse(0, 1100);
         chk("wake_wait", n >= lv && n <= lv + 12, 1'b1);
         chk("early_clk", hi, 0);
         chk("div_sel", clk_div_sel, 2'b01);
         await_pulse(1, 130);
         rd(8'hD7, 8'h00);
         rd(8'hD4, 8'h08);
         rd(8'hEE, 8'h01 << i);
         rd(8'h31, 8'h01);
         @(posedge sys_clk);
         ext_in <= 4'h0;
      end
      // every pin rose at least once above and nothing cleared the flags
      rd(8'hEF, 8'h0F);
      wr(8'hEF, 8'h05);
      rd(8'hEF, 8'h0A);
      wr(8'hF9, 8'h01);
      wr(8'hD7, 8'hA5);
      op(8'h7F);
      @(posedge sys_clk);
      watch_irq <= 1'b1;
      repeat (8) @(posedge sys_clk);
      #1;
      chk("watch_main", main_osc_en, 1'b0);
      @(posedge sys_clk);
      watch_on_sub <= 1'b1;
      // stabilisation select is still the long one left by the last stop pass
      await_pulse(0, 1100);
      chk("watch_wait", n >= lv && n <= lv + 12, 1'b1);
      @(posedge sys_clk);
      watch_irq <= 1'b0;
      watch_on_sub <= 1'b0;
      await_pulse(1, 130);
      wr(8'hF5, 8'h12);
      wr(8'hD4, 8'h10);
      wr(8'h30, 8'h02);
      op(8'h6F);
      chk("idle_en", {cpu_clk_en, periph_clk_en, main_osc_en}, 3'b011);
      @(posedge sys_clk);
      irq_pending <= 1'b1;
      repeat (10) @(posedge sys_clk);
      #1;
      chk("masked", {cpu_clk_en, irq_service}, 2'b00);
      do_reset;
      rd(8'hD4, 8'h00);
      rd(8'h30, 8'h02);
      rd(8'hF5, 8'hFF);
      @(posedge sys_clk);
      irq_pending <= 1'b0;
      wr(8'hD4, 8'h10);
      wr(8'h30, 8'h03);
      op(8'h6F);
      @(posedge sys_clk);
      irq_pending <= 1'b1;
      await_pulse(0, 4);
      chk("div_sel", clk_div_sel, 2'b10);
      @(posedge sys_clk);
      irq_pending <= 1'b0;
      await_pulse(1, 130);
      wr(8'hD4, 8'h18);
      wr(8'hD7, 8'hA5);
      op(8'h7F);
      do_reset;
      rd(8'hD4, 8'h00);
      rd(8'hD7, 8'h00);
      end_sim;
   end
   // cuts a hang short well past the longest expected run
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         miscompares++;
         end_sim;
      end
   end
endmodule // tb_pd_ctrl
